// [core/dcm_core.sv]
// ADC DC level measurement: two channel filters behind a Wishbone slave
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps

// Operation
// - The left channel filter runs only while the left enable bit is set.
// - The right channel filter runs only while its own enable bit is set.
// - Filter select zero averages blocks of two to the shift samples, at most 2^20 samples.
// - Filter select one runs a low-pass IIR whose time constant is set by the shift.
// - While the freeze bit is set no result register is refreshed.
// - In IIR mode results are live, or latched just before each clear.
// - Window code 0 never clears the IIR, code n up to 20 clears every 2^n clocks, codes above 20 every 2^20.
// - Left result reads as high, middle, low byte at three indices.
// - Right high and middle bytes follow the left low byte.
// - Right low byte follows the right middle byte.
// - Result bytes are read only and read zero until first result.
module dcm_core
  import dcm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register bus
  input  wire dcm_wb_req_t wb_req,
  output dcm_wb_rsp_t      wb_rsp,
  // ADC samples
  input  wire dcm_sample_t adc_in
);

  dcm_state_t s_q;
  dcm_state_t s_d;

  logic [7:0]           idx;
  logic                 hit;
  logic [4:0]           shift;
  logic [4:0]           win_code;
  logic [DCM_CNT_W-1:0] win_last;
  logic                 win_clr;
  logic                 freeze;
  logic                 capture;
  logic                 iir_sel;

  // Last count of a block of 2^n; codes above 20 saturate the mask
  function automatic logic [DCM_CNT_W-1:0] last_of(input logic [4:0] n);
    logic [DCM_CNT_W:0] one;
    one = '0;
    one[0] = 1'b1;
    last_of = DCM_CNT_W'((one << n) - 1'b1);
  endfunction : last_of

  // One channel step; results move only when not frozen
  function automatic dcm_chan_t chan_next(
    input dcm_chan_t            c,
    input logic                 en,
    input logic [DCM_RES_W-1:0] x,
    input logic                 vld,
    input logic                 iir,
    input logic [4:0]           d,
    input logic                 clr,
    input logic                 cap,
    input logic                 frz
  );
    dcm_chan_t                   n;
    logic signed [DCM_ACC_W-1:0] xs;
    logic signed [DCM_ACC_W-1:0] sum;
    n   = c;
    xs  = DCM_ACC_W'(signed'(x));
    sum = '0;
    if (!en) begin
      // Results stay readable; only the filter restarts from zero
      n.acc = '0;
      n.cnt = '0;
    end else if (iir) begin
      if (clr) begin
        // A sample landing on the clear edge is dropped with the old state
        if (cap && !frz) begin
          n.result = DCM_RES_W'(c.acc >>> d);
        end
        n.acc = '0;
        n.cnt = '0;
      end else if (vld) begin
        sum   = c.acc + xs - (c.acc >>> d);
        n.acc = sum;
        if (!cap && !frz) begin
          n.result = DCM_RES_W'(sum >>> d);
        end
      end
    end else if (vld) begin
      sum = c.acc + xs;
      if (c.cnt == last_of(d)) begin
        if (!frz) begin
          n.result = DCM_RES_W'(sum >>> d);
        end
        n.acc = '0;
        n.cnt = '0;
      end else begin
        n.acc = sum;
        n.cnt = c.cnt + 1'b1;
      end
    end
    return n;
  endfunction : chan_next

  assign idx      = wb_req.adr[DCM_ADR_W-1:2];
  assign hit      = wb_req.cyc && wb_req.stb && !s_q.ack;
  assign shift    = s_q.cfg[DCM_CFG_SHIFT_HI:DCM_CFG_SHIFT_LO];
  assign iir_sel  = s_q.cfg[DCM_CFG_IIR];
  assign win_code = s_q.upd[DCM_UPD_WIN_HI:DCM_UPD_WIN_LO];
  assign freeze   = s_q.upd[DCM_UPD_FREEZE];
  assign capture  = s_q.upd[DCM_UPD_CAPTURE];
  assign win_last = last_of(win_code);
  // Code zero means endless averaging, so no clear ever fires
  assign win_clr  = (win_code != 5'h00) && (s_q.win == win_last);

  always_comb begin
    s_d = s_q;

    // Window timer counts modulator clocks, i.e. every clk
    if (win_code == 5'h00 || win_clr) begin
      s_d.win = '0;
    end else begin
      s_d.win = s_q.win + 1'b1;
    end

    s_d.ch[1] = chan_next(s_q.ch[1], s_q.cfg[DCM_CFG_LEFT_EN],
                          adc_in.left, adc_in.valid, iir_sel, shift,
                          win_clr, capture, freeze);
    s_d.ch[0] = chan_next(s_q.ch[0], s_q.cfg[DCM_CFG_RIGHT_EN],
                          adc_in.right, adc_in.valid, iir_sel, shift,
                          win_clr, capture, freeze);

    // Bus: answer one cycle after the request, drop ack the next cycle
    s_d.ack  = hit;
    s_d.rdat = '0;
    if (hit) begin
      if (wb_req.we && wb_req.sel[0]) begin
        // Result indices take no write
        unique case (idx)
          DCM_IDX_CFG: begin
            s_d.cfg = wb_req.dat[7:0];
          end
          DCM_IDX_UPD: begin
            s_d.upd = wb_req.dat[7:0];
            s_d.upd[DCM_UPD_RSV] = 1'b0;
          end
          default: begin
            s_d.cfg = s_q.cfg;
          end
        endcase
      end
      if (!wb_req.we) begin
        unique case (idx)
          DCM_IDX_CFG:     s_d.rdat[7:0] = s_q.cfg;
          DCM_IDX_UPD:     s_d.rdat[7:0] = s_q.upd;
          DCM_IDX_LEFT_H:  s_d.rdat[7:0] = s_q.ch[1].result[23:16];
          DCM_IDX_LEFT_M:  s_d.rdat[7:0] = s_q.ch[1].result[15:8];
          DCM_IDX_LEFT_L:  s_d.rdat[7:0] = s_q.ch[1].result[7:0];
          DCM_IDX_RIGHT_H: s_d.rdat[7:0] = s_q.ch[0].result[23:16];
          DCM_IDX_RIGHT_M: s_d.rdat[7:0] = s_q.ch[0].result[15:8];
          DCM_IDX_RIGHT_L: s_d.rdat[7:0] = s_q.ch[0].result[7:0];
          default:         s_d.rdat = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.cfg       <= DCM_CFG_RST;
      s_q.upd       <= DCM_UPD_RST;
      s_q.ch[0].result <= DCM_RESULT_RST;
      s_q.ch[1].result <= DCM_RESULT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_rsp.ack = s_q.ack;
  assign wb_rsp.dat = s_q.rdat;

endmodule : dcm_core

// [core/dcm_pkg.sv]
// Package for the ADC DC level measurement block: map, fields, carriers
package dcm_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] DCM_IDX_CFG     = 8'h66;
  localparam logic [7:0] DCM_IDX_UPD     = 8'h67;
  localparam logic [7:0] DCM_IDX_LEFT_H  = 8'h68;
  localparam logic [7:0] DCM_IDX_LEFT_M  = 8'h69;
  localparam logic [7:0] DCM_IDX_LEFT_L  = 8'h6a;
  localparam logic [7:0] DCM_IDX_RIGHT_H = 8'h6b;
  localparam logic [7:0] DCM_IDX_RIGHT_M = 8'h6c;
  localparam logic [7:0] DCM_IDX_RIGHT_L = 8'h6d;

  // Reset values
  localparam logic [7:0]  DCM_CFG_RST    = 8'h00;
  localparam logic [7:0]  DCM_UPD_RST    = 8'h00;
  localparam logic [23:0] DCM_RESULT_RST = 24'h000000;

  // Field positions in the configuration register
  localparam int DCM_CFG_LEFT_EN  = 7;
  localparam int DCM_CFG_RIGHT_EN = 6;
  localparam int DCM_CFG_IIR      = 5;
  localparam int DCM_CFG_SHIFT_HI = 4;
  localparam int DCM_CFG_SHIFT_LO = 0;

  // Field positions in the update control register
  localparam int DCM_UPD_RSV      = 7;
  localparam int DCM_UPD_FREEZE   = 6;
  localparam int DCM_UPD_CAPTURE  = 5;
  localparam int DCM_UPD_WIN_HI   = 4;
  localparam int DCM_UPD_WIN_LO   = 0;

  // Datapath widths
  localparam int DCM_RES_W = 24;
  localparam int DCM_ACC_W = 44;
  localparam int DCM_CNT_W = 20;
  localparam int DCM_ADR_W = 10;

  // Wishbone request from the master
  typedef struct packed {
    logic                 cyc;
    logic                 stb;
    logic                 we;
    logic [DCM_ADR_W-1:0] adr;
    logic [3:0]           sel;
    logic [31:0]          dat;
  } dcm_wb_req_t;

  // Wishbone answer to the master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } dcm_wb_rsp_t;

  // One stereo ADC sample, valid for one clock
  typedef struct packed {
    logic                 valid;
    logic [DCM_RES_W-1:0] left;
    logic [DCM_RES_W-1:0] right;
  } dcm_sample_t;

  // Filter state of one channel
  typedef struct packed {
    logic signed [DCM_ACC_W-1:0] acc;
    logic [DCM_CNT_W-1:0]        cnt;
    logic [DCM_RES_W-1:0]        result;
  } dcm_chan_t;

  // Whole state of the block
  typedef struct packed {
    logic [7:0]           cfg;
    logic [7:0]           upd;
    logic [DCM_CNT_W-1:0] win;
    dcm_chan_t [1:0]      ch;
    logic                 ack;
    logic [31:0]          rdat;
  } dcm_state_t;

endpackage : dcm_pkg

// [verification/dcm_properties.sv]
// Concurrent checks on the ports of the DC level measurement block
`timescale 1ns/1ps
module dcm_properties
  import dcm_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Watched ports
  input wire dcm_wb_req_t wb_req,
  input wire dcm_wb_rsp_t wb_rsp,
  input wire dcm_sample_t adc_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       take, rd_q, seen_q;
  logic [7:0] idx_q, cfg_q, upd_q;
  assign take = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  // Shadows let readback be judged without looking inside the block
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {rd_q, seen_q, idx_q, cfg_q, upd_q} <= '0;
    end else begin
      rd_q   <= take && !wb_req.we;
      idx_q  <= wb_req.adr[9:2];
      seen_q <= seen_q || adc_in.valid;
      if (take && wb_req.we && wb_req.sel[0]) begin
        if (wb_req.adr[9:2] == DCM_IDX_CFG) cfg_q <= wb_req.dat[7:0];
        if (wb_req.adr[9:2] == DCM_IDX_UPD) upd_q <= {1'b0, wb_req.dat[6:0]};
      end
    end
  end
  property p_ack_next; take |=> wb_rsp.ack; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing after request");
  property p_ack_once; wb_rsp.ack |=> !wb_rsp.ack; endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack longer than one cycle");
  property p_ack_cause; $rose(wb_rsp.ack) |-> $past(take); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_idle_zero; !wb_rsp.ack |-> wb_rsp.dat == '0; endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("read data outside ack");
  property p_byte_only; wb_rsp.ack |-> wb_rsp.dat[31:8] == '0; endproperty
  a_byte_only: assert property (p_byte_only)
    else $error("upper read bits set");
  property p_cfg_back;
    rd_q && idx_q == DCM_IDX_CFG |-> wb_rsp.dat[7:0] == cfg_q;
  endproperty
  a_cfg_back: assert property (p_cfg_back)
    else $error("config readback wrong");
  property p_upd_back;
    rd_q && idx_q == DCM_IDX_UPD |-> wb_rsp.dat[7:0] == upd_q;
  endproperty
  a_upd_back: assert property (p_upd_back)
    else $error("update control readback wrong");
  property p_res_zero;
    rd_q && !seen_q && idx_q inside {[8'h68:8'h6d]} |-> wb_rsp.dat == '0;
  endproperty
  a_res_zero: assert property (p_res_zero)
    else $error("result nonzero before any sample");
endmodule : dcm_properties

// [verification/tb_dcm_core.sv]
// Self-checking bench for the DC level measurement block
`timescale 1ns/1ps
module tb_dcm_core;
  import dcm_pkg::*;
  logic        clk, rst_n;
  dcm_wb_req_t req;
  dcm_wb_rsp_t rsp;
  dcm_sample_t smp;
  logic [31:0] q;
  int          err_total, check_count;
  dcm_core dcm_core_inst (.clk(clk), .rst_n(rst_n), .wb_req(req),
                          .wb_rsp(rsp), .adc_in(smp));
  always #10 clk = ~clk;
  task automatic wrap_up;
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, {i, 2'b00}, 4'hf, {24'h0, d}};
    @(posedge clk);
    while (rsp.ack !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    q = rsp.dat;
    req <= '0;
    if (n == 20) err_total++;
  endtask : xfer
  task automatic chk(input logic [7:0] i, input logic [7:0] e);
    xfer(1'b0, i, 8'h00);
    check_count++;
    if (q !== {24'h0, e}) begin
      err_total++;
      $display("unexpected reg %h: expected %h, seen %h", i, e, q);
    end
  endtask : chk
  task automatic res(input logic [7:0] i, input logic [23:0] e);
    chk(i, e[23:16]);
    chk(i + 8'h01, e[15:8]);
    chk(i + 8'h02, e[7:0]);
  endtask : res
  // A gap cycle between samples keeps valid a clean one-cycle strobe
  task automatic put(input logic [23:0] l, input logic [23:0] r);
    @(posedge clk);
    smp <= '{1'b1, l, r};
    @(posedge clk);
    smp.valid <= 1'b0;
  endtask : put
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    smp = '0;
    err_total = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 8'h66; i < 8'h6e; i++) chk(i[7:0], 8'h00);
    xfer(1'b1, DCM_IDX_LEFT_H, 8'h5a);
    chk(DCM_IDX_LEFT_H, 8'h00);
    chk(8'h70, 8'h00);
    xfer(1'b1, DCM_IDX_CFG, 8'h81);
    put(24'h123456, 24'h0a0b0c);
    put(24'h123458, 24'h0a0b0e);
    res(DCM_IDX_LEFT_H, 24'h123457);
    res(DCM_IDX_RIGHT_H, 24'h000000);
    xfer(1'b1, DCM_IDX_CFG, 8'hc1);
    put(24'h123456, 24'h0a0b0c);
    put(24'h123458, 24'h0a0b0e);
    res(DCM_IDX_RIGHT_H, 24'h0a0b0d);
    chk(DCM_IDX_RIGHT_L, 8'h0d);
    xfer(1'b1, DCM_IDX_UPD, 8'h40);
    put(24'h000100, 24'h000100);
    put(24'h000100, 24'h000100);
    res(DCM_IDX_LEFT_H, 24'h123457);
    xfer(1'b1, DCM_IDX_UPD, 8'hc0);
    chk(DCM_IDX_UPD, 8'h40);
    xfer(1'b1, DCM_IDX_UPD, 8'h00);
    put(24'h000100, 24'h000100);
    put(24'h000100, 24'h000100);
    res(DCM_IDX_LEFT_H, 24'h000100);
    xfer(1'b1, DCM_IDX_CFG, 8'h00);
    xfer(1'b1, DCM_IDX_CFG, 8'ha1);
    repeat (40) put(24'h000200, 24'h000000);
    res(DCM_IDX_LEFT_H, 24'h000200);
    // Capture mode with an endless window never writes a result
    xfer(1'b1, DCM_IDX_UPD, 8'h20);
    repeat (20) put(24'h000300, 24'h000000);
    res(DCM_IDX_LEFT_H, 24'h000200);
    // A 32-clock window spans about 15 samples, enough to settle at 2x
    xfer(1'b1, DCM_IDX_UPD, 8'h25);
    repeat (40) put(24'h000300, 24'h000000);
    xfer(1'b1, DCM_IDX_UPD, 8'h65);
    res(DCM_IDX_LEFT_H, 24'h000300);
    xfer(1'b1, DCM_IDX_UPD, 8'h00);
    xfer(1'b1, DCM_IDX_CFG, 8'h21);
    put(24'h7fffff, 24'h000000);
    res(DCM_IDX_LEFT_H, 24'h000300);
    wrap_up();
  end
endmodule : tb_dcm_core
bind dcm_core dcm_properties dcm_properties_inst (.clk(clk), .rst_n(rst_n),
  .wb_req(wb_req), .wb_rsp(wb_rsp), .adc_in(adc_in));
